// >>> src/ddfd_consts.vh
// constants for the dual dac serial frame decoder
// assumes a 24-bit msb-first frame, 12-bit codes in the top data bits
`ifndef DDFD_CONSTS_VH
`define DDFD_CONSTS_VH
`define DDFD_FRAME_BITS   24
`define DDFD_CNT_W        5
`define DDFD_RW_BIT       23
`define DDFD_ZERO_BIT     22
`define DDFD_REG_HI       21
`define DDFD_REG_LO       19
`define DDFD_CH_HI        18
`define DDFD_CH_LO        16
`define DDFD_DATA_HI      15
`define DDFD_CODE_LO      4
`define DDFD_REG_DAC      3'h0
`define DDFD_REG_RANGE    3'h1
`define DDFD_REG_POWER    3'h2
`define DDFD_REG_CTRL     3'h3
`define DDFD_CH_A         3'h0
`define DDFD_CH_B         3'h2
`define DDFD_CH_BOTH      3'h4
`define DDFD_CODE_RST     12'h000
`define DDFD_WORD_RST     16'h0000
`endif

// >>> src/ddfd_frame_decoder.v
// serial command frame decoder for a dual-channel dac
// assumes sclk, sync_n and serial_data_in come from the host, asynchronous
// to ref_clk and slow enough to oversample (sclk well below ref_clk/4)
`timescale 1ns/10ps
`include "ddfd_consts.vh"

module ddfd_frame_decoder #(
    parameter FRAME_BITS = `DDFD_FRAME_BITS
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // serial link
    input  wire        sclk,
    input  wire        sync_n,
    input  wire        serial_data_in,
    output wire        sdo,
    // decoded registers
    output reg  [11:0] code_a_ff,
    output reg  [11:0] code_b_ff,
    output reg  [15:0] range_a_ff,
    output reg  [15:0] range_b_ff,
    output reg  [15:0] power_ff,
    output reg  [15:0] control_ff,
    // offset binary view of codes once written; reset clears both to 000 like the codes
    output reg  [11:0] code_a_bin_ff,
    output reg  [11:0] code_b_bin_ff,
    // frame status
    output reg         frame_done_ff,
    output reg         frame_bad_ff,
    output reg         zero_bit_err_ff
);

    reg  [2:0]  sclk_sync_ff;
    reg  [1:0]  sync_n_sync_ff;
    reg  [1:0]  sdi_sync_ff;
    reg         sync_n_d_ff;
    reg  [23:0] shift_ff;
    reg  [`DDFD_CNT_W-1:0] cnt_ff;
    reg  [15:0] rd_ff;
    reg  [15:0] tx_ff;

    wire sclk_rise  = sclk_sync_ff[1] & ~sclk_sync_ff[2];
    wire sclk_fall  = ~sclk_sync_ff[1] & sclk_sync_ff[2];
    wire in_frame   = ~sync_n_sync_ff[1];
    wire frame_end  = sync_n_sync_ff[1] & ~sync_n_d_ff;
    wire frame_ok   = frame_end & (cnt_ff == FRAME_BITS[`DDFD_CNT_W-1:0]);

    wire        rw_flag  = shift_ff[`DDFD_RW_BIT];
    wire [2:0]  reg_sel  = shift_ff[`DDFD_REG_HI:`DDFD_REG_LO];
    wire [2:0]  ch_sel   = shift_ff[`DDFD_CH_HI:`DDFD_CH_LO];
    wire [15:0] data     = shift_ff[`DDFD_DATA_HI:0];
    // 12-bit code, low four bits ignored
    wire [11:0] code     = data[`DDFD_DATA_HI:`DDFD_CODE_LO];

    // channel hit: own code or the both-channels code
    // codes 001, 011, 101 to 111 hit no channel at all
    function chan_hit;
        input [2:0] sel;
        input [2:0] own;
        begin
            chan_hit = (sel == own) | (sel == `DDFD_CH_BOTH);
        end
    endfunction

    // readback word of a per-channel register
    // a both-channels read returns channel a, b only when b alone is named
    function [15:0] pick_word;
        input        b_only;
        input [15:0] wa;
        input [15:0] wb;
        begin
            pick_word = b_only ? wb : wa;
        end
    endfunction

    wire sel_a  = chan_hit(ch_sel, `DDFD_CH_A);
    wire sel_b  = chan_hit(ch_sel, `DDFD_CH_B);
    wire only_b = sel_b & ~sel_a;

    // bipolar twos complement to offset binary: flip the sign bit
    function [11:0] to_offset;
        input [11:0] c;
        to_offset = {~c[11], c[10:0]};
    endfunction

    // sdo carries the word latched by the previous read frame only
    assign sdo = tx_ff[15];

    // two flops on every pin before any logic reads it
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sclk_sync_ff   <= 3'h0;
            sync_n_sync_ff <= 2'h3;
            sdi_sync_ff    <= 2'h0;
            sync_n_d_ff    <= 1'h1;
        end else begin
            sclk_sync_ff   <= {sclk_sync_ff[1:0], sclk};
            sync_n_sync_ff <= {sync_n_sync_ff[0], sync_n};
            sdi_sync_ff    <= {sdi_sync_ff[0], serial_data_in};
            sync_n_d_ff    <= sync_n_sync_ff[1];
        end
    end

    // msb first shift on rising sclk
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            shift_ff <= 24'h000000;
            cnt_ff   <= {`DDFD_CNT_W{1'b0}};
        end else if (frame_end) begin
            // every frame counts from zero again
            cnt_ff <= {`DDFD_CNT_W{1'b0}};
        end else if (in_frame && sclk_rise) begin
            shift_ff <= {shift_ff[22:0], sdi_sync_ff[1]};
            // saturate so a long frame never wraps back to 24
            if (cnt_ff != {`DDFD_CNT_W{1'b1}}) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    // readback word leaves on falling sclk during the next frame
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_ff <= `DDFD_WORD_RST;
        end else if (~sync_n_sync_ff[1] && sync_n_d_ff) begin
            // load at frame start wins over a shift in the same cycle
            tx_ff <= rd_ff;
        end else if (in_frame && sclk_fall) begin
            tx_ff <= {tx_ff[14:0], 1'b0};
        end
    end

    // wrong length is discarded, pulses last one cycle
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            frame_done_ff   <= 1'h0;
            frame_bad_ff    <= 1'h0;
            zero_bit_err_ff <= 1'h0;
        end else begin
            frame_done_ff <= frame_ok;
            frame_bad_ff  <= frame_end & ~frame_ok;
            if (frame_ok) begin
                zero_bit_err_ff <= shift_ff[`DDFD_ZERO_BIT];
            end
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            code_a_ff       <= `DDFD_CODE_RST;
            code_b_ff       <= `DDFD_CODE_RST;
            code_a_bin_ff   <= `DDFD_CODE_RST;
            code_b_bin_ff   <= `DDFD_CODE_RST;
            range_a_ff      <= `DDFD_WORD_RST;
            range_b_ff      <= `DDFD_WORD_RST;
            power_ff        <= `DDFD_WORD_RST;
            control_ff      <= `DDFD_WORD_RST;
            rd_ff           <= `DDFD_WORD_RST;
        end else begin
            // act only on complete released frame
            if (frame_ok) begin
                if (rw_flag) begin
                    case (reg_sel)
                        `DDFD_REG_DAC:
                            rd_ff <= pick_word(only_b, {code_a_ff, 4'h0},
                                               {code_b_ff, 4'h0});
                        `DDFD_REG_RANGE:
                            rd_ff <= pick_word(only_b, range_a_ff, range_b_ff);
                        `DDFD_REG_POWER: rd_ff <= power_ff;
                        `DDFD_REG_CTRL:  rd_ff <= control_ff;
                        default:         rd_ff <= `DDFD_WORD_RST;
                    endcase
                end else begin
                    case (reg_sel)
                        `DDFD_REG_DAC: begin
                            if (sel_a) begin
                                code_a_ff     <= code;
                                code_a_bin_ff <= to_offset(code);
                            end
                            if (sel_b) begin
                                code_b_ff     <= code;
                                code_b_bin_ff <= to_offset(code);
                            end
                        end
                        `DDFD_REG_RANGE: begin
                            if (sel_a)
                                range_a_ff <= data;
                            if (sel_b)
                                range_b_ff <= data;
                        end
                        `DDFD_REG_POWER: power_ff   <= data;
                        `DDFD_REG_CTRL:  control_ff <= data;
                        default:         power_ff   <= power_ff;
                    endcase
                end
            end
        end
    end

endmodule // ddfd_frame_decoder

// >>> bench/ddfd_host.sv
// host serial port model driving the decoder link
// assumes each frame is started just after a ref_clk edge
`timescale 1ns/10ps
module ddfd_host (
    // serial link
    output reg  sclk = 1'b0,
    output reg  sync_n = 1'b1,
    output reg  serial_data_in = 1'b0,
    input  wire sdo
);
    reg [23:0] rd;
    // msb first; length and reserved bit as built by the caller
    task send(input [23:0] w, input [7:0] n);
        integer i;
        begin
            sync_n = 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                #400 sclk = 1'b0;
                serial_data_in = i < 24 ? w[23 - i] : 1'b0;
                #400 sclk = 1'b1;
                rd = {rd[22:0], sdo};
            end
            #400 sclk = 1'b0;
            #400 sync_n = 1'b1;
            // released line must not look held
            serial_data_in = ~serial_data_in;
            #1000;
        end
    endtask
endmodule // ddfd_host

// >>> bench/ddfd_frame_decoder_sva.sv
// checker bound to the frame decoder ports
// assumes sclk is slow and still between frames
`timescale 1ns/10ps
module ddfd_chk (
    // clock, reset, link
    input wire        ref_clk, sys_rst, sclk, sync_n, serial_data_in,
    // outputs
    input wire [11:0] code_a_ff, code_b_ff,
    input wire        frame_done_ff, frame_bad_ff, zero_bit_err_ff
);
    reg        sk_ff, sn_ff;
    reg [4:0]  cnt_ff;
    reg [23:0] sr_ff;
    always @(posedge ref_clk) begin
        sk_ff <= sclk;
        sn_ff <= sync_n;
        if (sys_rst || (sn_ff && !sync_n)) cnt_ff <= 5'h00;
        else if (!sync_n && sclk && !sk_ff) begin
            {cnt_ff, sr_ff} <= {cnt_ff + 5'h01, sr_ff[22:0], serial_data_in};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    full_act_a: assert property ($rose(sync_n) && cnt_ff==5'h18 |-> ##[3:6] frame_done_ff)
        else $error("frame ignored");
    short_drop_a: assert property ($rose(sync_n) && cnt_ff!=5'h18 |-> ##[3:6] frame_bad_ff)
        else $error("bad length kept");
    after_rel_a: assert property (frame_done_ff |-> $past(sync_n, 3))
        else $error("acted in frame");
    done_pulse_a: assert property (frame_done_ff |=> !frame_done_ff)
        else $error("done too long");
    zero_flag_a: assert property (frame_done_ff |=> zero_bit_err_ff == sr_ff[22])
        else $error("zero flag wrong");
    code_a_a: assert property (frame_done_ff && sr_ff[23:16]==8'h00 |=> code_a_ff == sr_ff[15:4])
        else $error("code a wrong");
    both_ch_a: assert property (frame_done_ff && sr_ff[23:16]==8'h04 |=> code_b_ff == code_a_ff)
        else $error("both differ");
    read_keep_a: assert property (frame_done_ff && sr_ff[23] |-> $stable(code_a_ff))
        else $error("read wrote");
    cover property (frame_done_ff);
    cover property (frame_bad_ff);
    cover property (zero_bit_err_ff);
endmodule // ddfd_chk
bind ddfd_frame_decoder ddfd_chk ddfd_chk_i (.*);

// >>> bench/test_ddfd_frame_decoder.sv
// self-checking bench for the frame decoder
// assumes the host model owns the link
`timescale 1ns/10ps
module test_ddfd_frame_decoder;
    reg          ref_clk = 1'b0, sys_rst = 1'b1;
    wire         sclk, sync_n, serial_data_in, sdo, frame_done_ff, frame_bad_ff, zero_bit_err_ff;
    wire [11:0]  code_a_ff, code_b_ff, code_a_bin_ff, code_b_bin_ff;
    wire [15:0]  range_a_ff, range_b_ff, power_ff, control_ff;
    wire [111:0] st = {code_a_ff, code_b_ff, code_a_bin_ff, code_b_bin_ff,
                       range_a_ff, range_b_ff, power_ff, control_ff};
    reg  [11:0]  ea = 12'h000, eb = 12'h000, xa = 12'h000, xb = 12'h000;
    reg  [15:0]  ra = 16'h0000, pw = 16'h0000, ct = 16'h0000;
    integer      miscompares = 0, checks = 0, cyc = 0, k;
    // top byte is the bit count: 8'h17 is a refused length
    localparam [383:0] TBL = {32'h1800123f, 32'h18048000, 32'h18027ff0, 32'h1801fff0,
        32'h180c0006, 32'h18100015, 32'h18180001, 32'h18600000, 32'h17001110,
        32'h18200abc, 32'h18800000, 32'h18800000};
    always #50 ref_clk = ~ref_clk;
    ddfd_frame_decoder ddfd_frame_decoder_i (.*);
    ddfd_host ddfd_host_i (.*);
    task chk(input [111:0] s, e, input [63:0] nm);
        begin
            checks = checks + 1;
            if (s !== e) begin
                miscompares = miscompares + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d miscompares %0d", checks, miscompares);
            if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task frame(input [31:0] t);
        begin
            @(posedge ref_clk) #1;
            ddfd_host_i.send(t[23:0], t[31:24]);
            if (t[31:24] == 8'h18 && !t[23]) case (t[21:16])
                6'h00: {ea, xa} = {t[15:4], ~t[15], t[14:4]};
                6'h02: {eb, xb} = {t[15:4], ~t[15], t[14:4]};
                6'h04: {ea, eb, xa, xb} = {t[15:4], t[15:4], ~t[15], t[14:4], ~t[15], t[14:4]};
                6'h0c: ra = t[15:0];
                6'h10: pw = t[15:0];
                6'h18: ct = t[15:0];
            endcase
            chk(st, {ea, eb, xa, xb, ra, ra, pw, ct}, "regs");
        end
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        for (k = 0; k < 12; k = k + 1) frame(TBL[383 - 32 * k -: 32]);
        chk(ddfd_host_i.rd[23:8], {ea, 4'h0}, "readback");
        end_sim;
    end
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            end_sim;
        end
    end
endmodule // test_ddfd_frame_decoder
